//--- design/can_cmd_status.sv
// command and status logic of the can controller, avalon-mm register slave
// assumes bit stream engine supplies activity, result and counter signals
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "can_cmd_params.svh"
module can_cmd_status
    import can_cmd_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    input  wire logic [5:0] avs_address_i,
    input  wire logic       avs_read_i,
    input  wire logic       avs_write_i,
    input  wire logic [3:0] avs_byteenable_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic [31:0]     avs_readdata_o,
    output logic            avs_waitrequest_o,
    input  wire logic       bus_off_i,
    input  wire logic [7:0] tx_err_count_i,
    input  wire logic [7:0] rx_err_count_i,
    input  wire logic       tx_start_i,
    input  wire logic       tx_end_ok_i,
    input  wire logic       tx_end_fail_i,
    input  wire logic       rx_active_i,
    input  wire logic       rx_valid_i,
    input  wire logic       rx_accept_i,
    input  wire logic       txbuf_write_i,
    output logic            tx_go_o,
    output logic            tx_single_shot_o,
    output logic            tx_loopback_o,
    output logic            txbuf_write_ok_o,
    output logic            tx_event_o,
    output logic            rx_event_clear_o,
    output logic            overrun_event_o
);
    logic        ack_q;
    logic [7:0]  cmd_pulse_q;
    logic [1:0]  gap_q;
    logic [7:0]  warn_limit_q;
    tx_state_type tx_state_q;
    logic        single_q;
    logic        loop_q;
    logic        done_q;
    logic        ovr_q;
    logic [7:0]  count_q;
    logic        tx_event_q;
    logic        ovr_event_q;
    logic        rxclr_q;
    logic [7:0]  status;
    logic        wr_cmd;
    logic        wr_ctrl;
    logic        send_cmd;
    logic        loop_cmd;
    logic        abort_cmd;
    logic        warn;
    logic        queue_full;

    // one wait state on every access keeps timing fixed at two cycles
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
        end
    end

    assign wr_cmd  = avs_write_i & ack_q & avs_byteenable_i[0]
                   & (avs_address_i == `CMD_ADDR);
    assign wr_ctrl = avs_write_i & ack_q & avs_byteenable_i[0]
                   & (avs_address_i == `CTRL_ADDR);

    // command capture; reserved bits masked off, a single cycle pulse
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_pulse_q <= 8'h00;
        end else if (wr_cmd && gap_q == 2'h0) begin
            cmd_pulse_q <= avs_writedata_i[7:0] & `CMD_USED_MASK;
        end else begin
            cmd_pulse_q <= 8'h00;
        end
    end

    // spacing counter: commands within two cycles of an accepted one are lost
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_q <= 2'h0;
        end else if (wr_cmd && gap_q == 2'h0) begin
            gap_q <= `CMD_GAP_CYCLES;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end
    end

    // warning limit register, reset to its documented default
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            warn_limit_q <= `WARN_LIMIT_RESET;
        end else if (wr_ctrl) begin
            warn_limit_q <= avs_writedata_i[7:0];
        end
    end

    // combined command decoding; send wins over loopback
    assign abort_cmd = cmd_pulse_q[`CMD_ABORT_BIT];
    assign send_cmd  = cmd_pulse_q[`CMD_SEND_BIT] | cmd_pulse_q[`CMD_LOOP_BIT];
    assign loop_cmd  = cmd_pulse_q[`CMD_LOOP_BIT]
                     & ~cmd_pulse_q[`CMD_SEND_BIT];

    // transmit request state; a zero write never touches it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_state_q <= TX_IDLE;
            single_q   <= 1'b0;
            loop_q     <= 1'b0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (send_cmd) begin
                        tx_state_q <= TX_PENDING;
                        single_q   <= abort_cmd;
                        loop_q     <= loop_cmd;
                    end
                end
                TX_PENDING: begin
                    if (tx_start_i) begin
                        tx_state_q <= TX_ACTIVE;
                    end else if (abort_cmd) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
                TX_ACTIVE: begin
                    // abort in flight: finish this frame, no retry
                    if (abort_cmd) begin
                        single_q <= 1'b1;
                    end
                    if (tx_end_ok_i || (tx_end_fail_i && single_q)) begin
                        tx_state_q <= TX_IDLE;
                    end else if (tx_end_fail_i) begin
                        tx_state_q <= TX_PENDING;
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    assign tx_go_o          = (tx_state_q == TX_PENDING);
    assign tx_single_shot_o = single_q;
    assign tx_loopback_o    = loop_q;
    assign txbuf_write_ok_o = txbuf_write_i & (tx_state_q == TX_IDLE);

    // send done: cleared by a new request, set by a good completion
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q <= 1'b1;
        end else if (tx_state_q == TX_ACTIVE && tx_end_ok_i) begin
            done_q <= 1'b1;
        end else if (tx_state_q == TX_IDLE && send_cmd) begin
            done_q <= 1'b0;
        end
    end

    // transmit event when the buffer frees, whether sent or aborted
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_event_q <= 1'b0;
        end else begin
            tx_event_q <= (tx_state_q == TX_ACTIVE
                           && (tx_end_ok_i || (tx_end_fail_i && single_q)))
                        || (tx_state_q == TX_PENDING && !tx_start_i
                           && abort_cmd);
        end
    end
    assign tx_event_o = tx_event_q;

    // receive queue occupancy in messages
    assign queue_full = (count_q == `QUEUE_SLOTS);
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_q <= 8'h00;
        end else begin
            case ({rx_valid_i & rx_accept_i & ~queue_full,
                   cmd_pulse_q[`CMD_RELEASE_BIT] & (count_q != 8'h00)})
                2'b10:   count_q <= count_q + 8'h01;
                2'b01:   count_q <= count_q - 8'h01;
                default: count_q <= count_q;
            endcase
        end
    end

    // receive event drops once the last message is released
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxclr_q <= 1'b0;
        end else begin
            rxclr_q <= cmd_pulse_q[`CMD_RELEASE_BIT]
                     & (count_q == 8'h01)
                     & ~(rx_valid_i & rx_accept_i);
        end
    end
    assign rx_event_clear_o = rxclr_q;

    // overrun: set beats clear so a lost message is never missed
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ovr_q       <= 1'b0;
            ovr_event_q <= 1'b0;
        end else begin
            // only a valid accepted frame counts; failed ones never do
            if (rx_valid_i && rx_accept_i && queue_full) begin
                ovr_q <= 1'b1;
            end else if (cmd_pulse_q[`CMD_CLR_OVR_BIT]) begin
                ovr_q <= 1'b0;
            end
            ovr_event_q <= rx_valid_i & rx_accept_i & queue_full
                         & ~ovr_q;
        end
    end
    assign overrun_event_o = ovr_event_q;

    // status assembly
    assign warn = (tx_err_count_i >= warn_limit_q)
                | (rx_err_count_i >= warn_limit_q);
    always_comb begin
        status = 8'h00;
        status[`ST_BUS_OFF_BIT]   = bus_off_i;
        status[`ST_WARN_BIT]      = warn;
        status[`ST_SENDING_BIT]   = (tx_state_q == TX_ACTIVE);
        status[`ST_RECEIVING_BIT] = rx_active_i;
        status[`ST_DONE_BIT]      = done_q;
        status[`ST_TXFREE_BIT]    = (tx_state_q == TX_IDLE);
        status[`ST_OVERRUN_BIT]   = ovr_q;
        status[`ST_RXFULL_BIT]    = (count_q != 8'h00);
    end

    // read mux; command register and unmapped offsets read zero
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            case (avs_address_i)
                `STAT_ADDR:      avs_readdata_o <= {24'h000000, status};
                `CTRL_ADDR:      avs_readdata_o <= {24'h000000, warn_limit_q};
                `MSG_COUNT_ADDR: avs_readdata_o <= {24'h000000, count_q};
                default:         avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // checks; all sample on the block clock and sleep during reset
    wr_zero_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        avs_read_i && !ack_q && avs_address_i == `CMD_ADDR
        |=> avs_readdata_o == 32'h0000_0000)
        else $error("command register read not zero");
    done_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_IDLE && send_cmd |=> !done_q)
        else $error("send done not cleared by request");
    done_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_ACTIVE && tx_end_ok_i |=> done_q)
        else $error("send done not set on success");
    // state and event move on the same edge, so both show together
    abort_pend_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_PENDING && !tx_start_i && abort_cmd
        |=> tx_state_q == TX_IDLE && tx_event_o)
        else $error("abort did not free buffer with event");
    abort_act_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_ACTIVE && abort_cmd |=> tx_single_shot_o)
        else $error("abort in flight left retry armed");
    one_shot_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_ACTIVE && tx_end_fail_i && tx_single_shot_o
        |=> tx_state_q == TX_IDLE)
        else $error("single-shot frame retried");
    keep_req_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_go_o && !tx_start_i && !abort_cmd |=> tx_go_o)
        else $error("pending request lost without abort");
    latch_clr_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_go_o && tx_start_i |=> !tx_go_o && status[`ST_SENDING_BIT])
        else $error("request latch not cleared on start");
    ovr_hold_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        ovr_q && !cmd_pulse_q[`CMD_CLR_OVR_BIT] |=> ovr_q)
        else $error("overrun flag dropped without clear");
    ovr_set_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        rx_valid_i && rx_accept_i && queue_full |=> ovr_q)
        else $error("lost message did not flag overrun");
    ovr_quiet_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        !ovr_q && !(rx_valid_i && rx_accept_i) |=> !ovr_q)
        else $error("overrun flagged without a valid frame");
    ovr_once_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        $past(ovr_q) && ovr_q |-> !overrun_event_o)
        else $error("repeated overrun event");
    ovr_rise_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        !ovr_q ##1 ovr_q |-> overrun_event_o)
        else $error("overrun flag rose without event");
    ovr_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        cmd_pulse_q[`CMD_CLR_OVR_BIT] && !(rx_valid_i && rx_accept_i)
        |=> !ovr_q)
        else $error("clear overrun did not clear");
    release_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        cmd_pulse_q[`CMD_RELEASE_BIT] && count_q != 8'h00
        && !(rx_valid_i && rx_accept_i)
        |=> count_q == $past(count_q) - 8'h01)
        else $error("release did not free one slot");
    rx_clear_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        rx_event_clear_o |-> count_q == 8'h00)
        else $error("receive event cleared with messages left");
    pulse_once_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        cmd_pulse_q != 8'h00 |=> cmd_pulse_q == 8'h00)
        else $error("command pulse persisted");
    loop_ign_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q == TX_IDLE && cmd_pulse_q[`CMD_SEND_BIT]
        |=> !tx_loopback_o)
        else $error("loopback not ignored with send");
    txbuf_a: assert property (@(posedge clk_sys_i)
        disable iff (!nrst_i)
        tx_state_q != TX_IDLE |-> !txbuf_write_ok_o)
        else $error("locked buffer accepted write");
    // main scenarios: send, abort, overrun, single-shot loopback, release
    send_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_state_q == TX_ACTIVE && tx_end_ok_i);
    abort_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_state_q == TX_PENDING && abort_cmd);
    ovr_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        overrun_event_o);
    loop_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        tx_state_q == TX_IDLE && loop_cmd && abort_cmd);
    rel_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        rx_event_clear_o);
endmodule
`default_nettype wire

//--- design/can_cmd_params.svh
// constants for the command and status block: offsets, bit positions, limits
// assumes inclusion by bare name from the package and design files
`ifndef CAN_CMD_PARAMS_SVH
`define CAN_CMD_PARAMS_SVH

`define CMD_REG_INDEX      4'h1
`define STAT_REG_INDEX     4'h2
`define CTRL_REG_INDEX     4'h6
`define MSG_COUNT_INDEX    4'h7
`define CMD_ADDR           6'h04
`define STAT_ADDR          6'h08
`define CTRL_ADDR          6'h18
`define MSG_COUNT_ADDR     6'h1C

`define CMD_SEND_BIT       0
`define CMD_ABORT_BIT      1
`define CMD_RELEASE_BIT    2
`define CMD_CLR_OVR_BIT    3
`define CMD_LOOP_BIT       4
`define CMD_USED_MASK      8'h1F

`define ST_BUS_OFF_BIT     7
`define ST_WARN_BIT        6
`define ST_SENDING_BIT     5
`define ST_RECEIVING_BIT   4
`define ST_DONE_BIT        3
`define ST_TXFREE_BIT      2
`define ST_OVERRUN_BIT     1
`define ST_RXFULL_BIT      0

`define WARN_LIMIT_RESET   8'h60
`define QUEUE_SLOTS        8'h08
`define CMD_GAP_CYCLES     2'h2

`endif

//--- design/can_cmd_pkg.sv
// types shared by the command and status block
// assumes the params header is on the include path
`include "can_cmd_params.svh"
package can_cmd_pkg;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_PENDING,
        TX_ACTIVE
    } tx_state_type;
endpackage

//--- verif/can_tx_engine_model.sv
// behavioural bit stream engine facing the transmit request of the block
// assumes one clock shared with the block and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module can_tx_engine_model #(
    parameter int FRAME_LEN = 12
) (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic tx_go_i,
    input  wire logic hold_i,
    input  wire logic fail_i,
    output logic      tx_start_o,
    output logic      tx_end_ok_o,
    output logic      tx_end_fail_o
);
    int cnt;

    // start a frame on a pending request, end it after a fixed length
    // hold_i stalls the start so the bench can abort or inspect a request
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt           <= 0;
            tx_start_o    <= 1'b0;
            tx_end_ok_o   <= 1'b0;
            tx_end_fail_o <= 1'b0;
        end else begin
            tx_start_o    <= 1'b0;
            tx_end_ok_o   <= 1'b0;
            tx_end_fail_o <= 1'b0;
            if (cnt == 0 && tx_go_i && !hold_i && !tx_start_o) begin
                tx_start_o <= 1'b1;
                cnt        <= FRAME_LEN;
            end else if (cnt == 1) begin
                tx_end_ok_o   <= !fail_i;
                tx_end_fail_o <= fail_i;
                cnt           <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_can_cmd_status.sv
// self-checking bench of the command and status block
// assumes the design files and the engine model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "can_cmd_params.svh"
module tb_can_cmd_status;
    import can_cmd_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [5:0]  adr = '0;
    logic [31:0] wdat = '0;
    logic [7:0]  txc = '0, rxc = '0;
    logic        boff = 0, rxa = 0, rxv = 0, rxacc = 0, tbw = 0;
    logic        hold = 0, fail = 0;
    logic [31:0] rdat;
    logic        wreq, st, eok, efl, go, ss, lb, tbok, txev, rxclr, ovev;
    logic [31:0] expq[$];
    int          fails = 0, n_checks = 0, n_ov = 0, n_clr = 0, seed;
    int          n_tx = 0, t0 = 0;
    logic [31:0] r;
    logic [7:0]  cm[5] = '{8'h03, 8'h12, 8'h13, 8'h11, 8'h10};
    logic [1:0]  ex[5] = '{2'b10, 2'b11, 2'b10, 2'b00, 2'b01};

    always #25 clk = ~clk;

    can_cmd_status dut_u (.clk_sys_i(clk), .nrst_i(nrst),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_byteenable_i(4'hF), .avs_writedata_i(wdat),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .bus_off_i(boff), .tx_err_count_i(txc), .rx_err_count_i(rxc),
        .tx_start_i(st), .tx_end_ok_i(eok), .tx_end_fail_i(efl),
        .rx_active_i(rxa), .rx_valid_i(rxv), .rx_accept_i(rxacc),
        .txbuf_write_i(tbw), .tx_go_o(go), .tx_single_shot_o(ss),
        .tx_loopback_o(lb), .txbuf_write_ok_o(tbok), .tx_event_o(txev),
        .rx_event_clear_o(rxclr), .overrun_event_o(ovev));

    can_tx_engine_model eng_u (.clk_sys_i(clk), .nrst_i(nrst),
        .tx_go_i(go), .hold_i(hold), .fail_i(fail), .tx_start_o(st),
        .tx_end_ok_o(eok), .tx_end_fail_o(efl));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one avalon access: raised after an edge, held until the edge at
    // which waitrequest is sampled low, released at that very edge
    task bus(input logic w, input logic [5:0] a, input logic [7:0] d,
             input logic [31:0] e);
        int n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        if (!w)
            expq.push_back(e);
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
            chk(1, 0);
        rd <= 1'b0;
        wr <= 1'b0;
        // one idle edge so the next access starts from a released bus
        @(posedge clk);
    endtask

    task rdx(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, e);
    endtask

    // commands keep the two-cycle spacing the block needs
    task cmd(input logic [7:0] d);
        bus(1'b1, `CMD_ADDR, d, 0);
        cyc(2);
    endtask

    // wait for a pulse: 0 start, 1 buffer freed, 2 failed frame end
    task waitp(input int k);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(k == 0 ? st : k == 1 ? txev : efl) && n < 200);
        if (n >= 200)
            chk(k, 32'hFF);
        @(posedge clk);
    endtask

    task tend(input string s);
        $display("test %s ended at %0t", s, $time);
    endtask

    // read data taken against the oldest note at the completing edge
    always @(posedge clk) begin
        if (rd && wreq === 1'b0)
            chk(rdat, expq.pop_front());
    end

    // event pulses counted mid-cycle, where they have settled
    always @(negedge clk) begin
        if (ovev === 1'b1)
            n_ov++;
        if (rxclr === 1'b1)
            n_clr++;
        if (txev === 1'b1)
            n_tx++;
    end

    initial begin
        seed = 32'hF68EA58A;
        cyc(20);
        nrst <= 1'b1;
        cyc(1);
        rdx(`STAT_ADDR, 32'h0C);
        rdx(`CMD_ADDR, 32'h0);
        rdx(6'h3C, 32'h0);
        rdx(`CTRL_ADDR, 32'h60);
        bus(1'b1, `STAT_ADDR, 8'hFF, 0);
        rdx(`STAT_ADDR, 32'h0C);
        boff <= 1'b1;
        txc <= 8'h60;
        rxa <= 1'b1;
        cyc(2);
        rdx(`STAT_ADDR, 32'hDC);
        boff <= 1'b0;
        rxa <= 1'b0;
        // counters kept below the limit, then one exactly on it
        repeat (4) begin
            r = $random(seed);
            txc <= r[7:0] % 8'h60;
            rxc <= r[15:8] % 8'h60;
            cyc(2);
            rdx(`STAT_ADDR, 32'h0C);
        end
        rxc <= 8'h60;
        cyc(2);
        rdx(`STAT_ADDR, 32'h4C);
        rxc <= 8'h00;
        tend("registers");
        hold <= 1'b1;
        cmd(8'h01);
        rdx(`STAT_ADDR, 32'h00);
        cmd(8'h00);
        chk(go, 1);
        tbw <= 1'b1;
        @(negedge clk);
        chk(tbok, 0);
        @(posedge clk);
        tbw <= 1'b0;
        hold <= 1'b0;
        waitp(0);
        cyc(1);
        chk(go, 0);
        rdx(`STAT_ADDR, 32'h20);
        waitp(1);
        cyc(1);
        rdx(`STAT_ADDR, 32'h0C);
        tend("send");
        hold <= 1'b1;
        cmd(8'h01);
        t0 = n_tx;
        cmd(8'h02);
        cyc(1);
        chk(n_tx, t0 + 1);
        rdx(`STAT_ADDR, 32'h04);
        chk(go, 0);
        // abort while the frame is on the bus: it ends, no retry
        fail <= 1'b1;
        cmd(8'h01);
        hold <= 1'b0;
        waitp(0);
        cmd(8'h02);
        waitp(2);
        hold <= 1'b1;
        cyc(2);
        chk(go, 0);
        fail <= 1'b0;
        hold <= 1'b0;
        tend("abort");
        // each combination fails once: single-shot must not retry
        for (int i = 0; i < 5; i++) begin
            hold <= 1'b1;
            fail <= 1'b1;
            cmd(cm[i]);
            chk({ss, lb}, ex[i]);
            hold <= 1'b0;
            waitp(2);
            hold <= 1'b1;
            cyc(2);
            chk(go, !ex[i][1]);
            fail <= 1'b0;
            hold <= 1'b0;
            if (!ex[i][1])
                waitp(1);
            cyc(4);
        end
        rdx(`STAT_ADDR, 32'h0C);
        tend("modes");
        rxv <= 1'b1;
        cyc(1);
        rxv <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rxv <= 1'b1;
            rxacc <= 1'b1;
            cyc(1);
            rxv <= 1'b0;
            rxacc <= 1'b0;
            cyc(1);
        end
        cyc(2);
        chk(n_ov, 1);
        rdx(`MSG_COUNT_ADDR, 32'h08);
        rdx(`STAT_ADDR, 32'h0F);
        cmd(8'h00);
        rdx(`STAT_ADDR, 32'h0F);
        cmd(8'h08);
        rdx(`STAT_ADDR, 32'h0D);
        repeat (7) cmd(8'h04);
        chk(n_clr, 0);
        cmd(8'h04);
        chk(n_clr, 1);
        rdx(`STAT_ADDR, 32'h0C);
        tend("receive");
        cmd(8'hE0);
        chk(go, 0);
        rdx(`STAT_ADDR, 32'h0C);
        tend("reserved");
        tbw <= 1'b1;
        @(negedge clk);
        chk(tbok, 1);
        @(posedge clk);
        tbw <= 1'b0;
        tend("buffer");
        report_and_stop();
    end

    // watchdog sized well beyond the whole sequence
    initial begin
        #(50 * 20000);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
